// ===== hdl/vr_startup_fault_supervisor.sv
// start-up sequencing, ready and over-current supervision for two rails
// assumes comparator inputs are asynchronous and the telemetry read port
// is driven by the serial bus logic on the same clock
`include "vr_supervisor_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module vr_startup_fault_supervisor
    import vr_supervisor_pkg::*;
#(
    parameter int OC_DLY_CYC   = `OC_DLY_CYC,
    parameter int CAL_CYC      = `CAL_CYC,
    parameter int RAIL0_PHASES = 4,
    parameter logic [7:0] OC_STEP_MV = 8'h1e
) (
    input  wire logic            clk_sys_i,
    input  wire logic            sys_rst_i,
    input  wire logic            enable_i,
    input  wire logic            input_supply_low_i,
    input  wire logic            bias_supply_low_i,
    input  wire rail_cmp_s [1:0] rail_cmp_i,
    input  wire vid_cmd_s [1:0]  vid_cmd_i,
    input  wire logic [1:0]      phase_shed_i,
    input  wire logic [4:0]      current_limit_program_pin_i,
    input  wire logic [2:0]      max_temperature_limit_trim_i,
    input  wire logic            reg_rd_i,
    input  wire logic            reg_rail_i,
    input  wire logic [7:0]      reg_addr_i,
    output logic                 reg_ack_o,
    output logic [7:0]           reg_rdata_o,
    output logic                 reg_unmapped_o,
    output logic                 supply_lockout_o,
    output rail_out_s [1:0]      rail_o,
    output logic [1:0]           regulator_ok_out_o,
    output logic [1:0]           regulator_ok_out_oe_o
);

    initial begin
        if (OC_DLY_CYC < 1 || OC_DLY_CYC > 131071) begin
            $error("OC_DLY_CYC out of range");
        end
        if (CAL_CYC < 1 || CAL_CYC > 131071) begin
            $error("CAL_CYC out of range");
        end
        if (RAIL0_PHASES < 4 || RAIL0_PHASES > 7) begin
            $error("RAIL0_PHASES out of range");
        end
        if (`EN_FILT_CYC < 1 || `EN_FILT_CYC > 64) begin
            $error("enable filter count out of range");
        end
        if (`STEP_CYC < 1 || `STEP_CYC > 32) begin
            $error("ramp step count out of range");
        end
        if (OC_STEP_MV == 8'h00 || int'(OC_STEP_MV) * 7 > 255) begin
            $error("OC_STEP_MV out of range for seven phases");
        end
        if (`CAL_US >= 1000) begin
            $error("calibration must end within one millisecond");
        end
        if (`BOOT_MV <= `PIN_FLOOR_MV) begin
            $error("boot level must lie above the pin floor");
        end
    end

    localparam logic [5:0]  EN_LAST   = 6'(`EN_FILT_CYC - 1);
    localparam logic [4:0]  STEP_LAST = 5'(`STEP_CYC - 1);
    localparam logic [16:0] OC_LAST   = 17'(OC_DLY_CYC - 1);
    localparam logic [16:0] CAL_LAST  = 17'(CAL_CYC - 1);

    // rail 0 maximum current from the program code
    function automatic logic [7:0] icc_rail0(input logic [4:0] code);
        logic [7:0] amps;
        amps = `ICC0_BASE_A + 8'(`ICC0_STEP_A * {4'h0, code[4:1]});
        if (code >= `ICC0_TOP_CODE) begin
            amps = `ICC0_TOP_A;
        end
        return amps;
    endfunction

    // one millivolt toward the target
    function automatic logic [10:0] slew(input logic [10:0] cur, input logic [10:0] tgt);
        logic [10:0] nxt;
        nxt = cur;
        if (cur < tgt) begin
            nxt = cur + 11'h001;
        end else if (cur > tgt) begin
            nxt = cur - 11'h001;
        end
        return nxt;
    endfunction

    // reference pin: calibration level, then the current-reporting floor
    function automatic logic [10:0] pin_level(input cal_state_e cal, input logic [10:0] ref_mv);
        logic [10:0] lvl;
        lvl = ref_mv;
        if (cal == CAL_RUN) begin
            lvl = `CAL_MV;
        end else if (cal == CAL_WAIT) begin
            lvl = 11'h000;
        end else if (ref_mv < `PIN_FLOOR_MV) begin
            lvl = `PIN_FLOOR_MV;
        end
        return lvl;
    endfunction

    sup_s s;
    sup_s next_s;

    always_comb begin
        logic       in_low;
        logic       bias_low;
        logic       en_raw;
        logic       tick;
        logic       go;
        logic [2:0] phases;
        logic       oc_hot;
        logic       level_ok;
        rail_cmp_s  c;
        in_low   = 1'b0;
        bias_low = 1'b0;
        en_raw   = 1'b0;
        tick     = 1'b0;
        go       = 1'b0;
        phases   = 3'h0;
        oc_hot   = 1'b0;
        level_ok = 1'b0;
        c        = '0;
        next_s   = s;

        // two flops on every pin-side input
        next_s.in_s1   = {enable_i, input_supply_low_i, bias_supply_low_i};
        next_s.in_s2   = s.in_s1;
        next_s.cmp_s1  = rail_cmp_i;
        next_s.cmp_s2  = s.cmp_s1;
        next_s.shed_s1 = phase_shed_i;
        next_s.shed_s2 = s.shed_s1;
        next_s.icc_s1  = current_limit_program_pin_i;
        next_s.icc_s2  = s.icc_s1;
        next_s.trim_s1 = max_temperature_limit_trim_i;
        next_s.trim_s2 = s.trim_s1;
        en_raw   = s.in_s2[2];
        in_low   = s.in_s2[1];
        bias_low = s.in_s2[0];

        next_s.lockout = in_low | bias_low;

        // enable must hold its new level for the whole filter time
        next_s.en_rise = 1'b0;
        if (en_raw == s.en_filt) begin
            next_s.en_cnt = 6'h00;
        end else if (s.en_cnt == EN_LAST) begin
            next_s.en_cnt  = 6'h00;
            next_s.en_filt = en_raw;
            next_s.en_rise = en_raw;
        end else begin
            next_s.en_cnt = s.en_cnt + 6'h01;
        end

        tick = (s.step_cnt == STEP_LAST);
        next_s.step_cnt = tick ? 5'h00 : s.step_cnt + 5'h01;

        // calibration runs once the input supply is in range
        case (s.cal_state)
            CAL_WAIT: begin
                next_s.cal_cnt = 17'h00000;
                if (!in_low) begin
                    next_s.cal_state = CAL_RUN;
                end
            end
            CAL_RUN: begin
                next_s.cal_cnt = s.cal_cnt + 17'h00001;
                if (s.cal_cnt == CAL_LAST) begin
                    next_s.cal_state = CAL_DONE;
                    next_s.icc_code  = s.icc_s2;
                end
            end
            default: begin
                next_s.cal_cnt = 17'h00000;
            end
        endcase
        if (in_low) begin
            next_s.cal_state = CAL_WAIT;
        end

        // trim selects the temperature limit
        next_s.max_temperature_limit = `MAX_TEMPERATURE_LIMIT_BASE_C + {3'h0, s.trim_s2, 2'b00};

        // reads answer one cycle later; unknown addresses return zero
        next_s.rd_ack      = reg_rd_i;
        next_s.rd_unmapped = 1'b0;
        next_s.rd_data     = 8'h00;
        if (reg_rd_i) begin
            if (reg_addr_i == `MAX_TEMPERATURE_LIMIT_ADDR) begin
                next_s.rd_data = s.max_temperature_limit;
            end else if (reg_addr_i == `MAX_SUPPORTED_CURRENT_ADDR) begin
                if (reg_rail_i) begin
                    next_s.rd_data = s.icc_code[0] ? `ICC1_HI_A : `ICC1_LO_A;
                end else begin
                    next_s.rd_data = icc_rail0(s.icc_code);
                end
            end else begin
                next_s.rd_unmapped = 1'b1;
            end
        end

        // both rails run the same supervision
        for (int r = 0; r < 2; r++) begin
            c  = s.cmp_s2[r];
            go = s.en_filt & ~next_s.lockout & (s.cal_state == CAL_DONE) & ~s.rail[r].oc_latch;

            case (s.rail[r].state)
                RAIL_OFF: begin
                    next_s.rail[r].ref_mv       = 11'h000;
                    next_s.rail[r].boot_reached = 1'b0;
                    next_s.rail[r].track_fail   = 1'b0;
                    next_s.rail[r].track_mode   = 1'b1;
                    next_s.rail[r].vid_pend     = 1'b0;
                    if (go && s.rail[r].ref_mv == 11'h000) begin
                        next_s.rail[r].state = RAIL_UP;
                    end
                end
                RAIL_UP: begin
                    if (c.below_track) begin
                        next_s.rail[r].track_fail = 1'b1;
                    end
                    if (!go) begin
                        next_s.rail[r].state = RAIL_DOWN;
                    end else if (s.rail[r].ref_mv == `BOOT_MV) begin
                        next_s.rail[r].state        = RAIL_ON;
                        next_s.rail[r].boot_reached = 1'b1;
                    end else if (tick) begin
                        next_s.rail[r].ref_mv = slew(s.rail[r].ref_mv, `BOOT_MV);
                    end
                end
                // bus commands honoured only once booted
                RAIL_ON: begin
                    if (!go) begin
                        next_s.rail[r].state = RAIL_DOWN;
                    end else begin
                        if (vid_cmd_i[r].cmd) begin
                            next_s.rail[r].vid_pend   = 1'b1;
                            next_s.rail[r].vid_target = vid_cmd_i[r].target;
                        end else if (s.rail[r].vid_pend && s.rail[r].ref_mv == s.rail[r].vid_target
                                     && c.settled) begin
                            next_s.rail[r].vid_pend   = 1'b0;
                            next_s.rail[r].track_mode = 1'b0;
                        end
                        if (tick && s.rail[r].vid_pend) begin
                            next_s.rail[r].ref_mv = slew(s.rail[r].ref_mv, s.rail[r].vid_target);
                        end
                    end
                end
                // internal reference keeps going down to zero
                default: begin
                    next_s.rail[r].boot_reached = 1'b0;
                    if (s.rail[r].ref_mv == 11'h000) begin
                        next_s.rail[r].state = RAIL_OFF;
                    end else if (tick) begin
                        next_s.rail[r].ref_mv = slew(s.rail[r].ref_mv, 11'h000);
                    end
                end
            endcase

            // over-current must persist, soft start included
            oc_hot = c.overcurrent && (s.rail[r].state != RAIL_OFF);
            if (oc_hot) begin
                if (s.rail[r].oc_cnt != OC_LAST) begin
                    next_s.rail[r].oc_cnt = s.rail[r].oc_cnt + 17'h00001;
                end
            end else begin
                next_s.rail[r].oc_cnt = 17'h00000;
            end
            // clear first so that a set in the same cycle wins
            if (bias_low || s.en_rise) begin
                next_s.rail[r].oc_latch = 1'b0;
            end
            if (oc_hot && s.rail[r].oc_cnt == OC_LAST) begin
                next_s.rail[r].oc_latch = 1'b1;
            end

            // tracking compare until a settled bus command hands over to the reference
            level_ok = s.rail[r].track_mode ? ~c.below_track : ~c.below_uv;
            next_s.rail[r].out.ready = next_s.rail[r].boot_reached & go & ~next_s.rail[r].track_fail
                & ~next_s.rail[r].oc_latch & level_ok;
            next_s.rail[r].out.soft_start_done = (next_s.rail[r].state == RAIL_ON)
                & (s.rail[r].out.soft_start_done | (next_s.rail[r].out.ready & c.settled));
            next_s.rail[r].out.oc_fault      = next_s.rail[r].oc_latch;
            next_s.rail[r].out.ea_force_low  = next_s.rail[r].oc_latch;
            next_s.rail[r].out.drive_inhibit = next_s.rail[r].oc_latch;
            next_s.rail[r].out.int_ref       = next_s.rail[r].ref_mv;

            next_s.rail[r].out.pin_ref = pin_level(next_s.cal_state, next_s.rail[r].ref_mv);

            // rail 1 is a single-phase rail
            phases = (r == 0) ? 3'(RAIL0_PHASES) - {1'b0, s.shed_s2} : 3'h1;
            next_s.rail[r].out.oc_offset = 8'(OC_STEP_MV * phases);
            next_s.rok_oe[r] = ~next_s.rail[r].out.ready;
        end
    end

    // reset holds both ready pins pulled low
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            s        <= '0;
            s.max_temperature_limit   <= `MAX_TEMPERATURE_LIMIT_RST;
            s.rok_oe <= 2'b11;
        end else begin
            s <= next_s;
        end
    end

    assign reg_ack_o             = s.rd_ack;
    assign reg_rdata_o           = s.rd_data;
    assign reg_unmapped_o        = s.rd_unmapped;
    assign supply_lockout_o      = s.lockout;
    assign rail_o                = {s.rail[1].out, s.rail[0].out};
    assign regulator_ok_out_o    = 2'b00;
    assign regulator_ok_out_oe_o = s.rok_oe;

endmodule

`default_nettype wire

// ===== hdl/vr_supervisor_pkg.sv
// types shared by the rail supervisor and its surroundings
// assumes comparator decisions arrive from the analog front end
package vr_supervisor_pkg;

    typedef enum logic [1:0] {RAIL_OFF, RAIL_UP, RAIL_ON, RAIL_DOWN} rail_state_e;
    typedef enum logic [1:0] {CAL_WAIT, CAL_RUN, CAL_DONE} cal_state_e;

    typedef struct packed {
        logic below_track;
        logic below_uv;
        logic settled;
        logic overcurrent;
    } rail_cmp_s;

    typedef struct packed {
        logic        cmd;
        logic [10:0] target;
    } vid_cmd_s;

    typedef struct packed {
        logic        ready;
        logic        soft_start_done;
        logic        oc_fault;
        logic        ea_force_low;
        logic        drive_inhibit;
        logic [10:0] int_ref;
        logic [10:0] pin_ref;
        logic [7:0]  oc_offset;
    } rail_out_s;

    typedef struct packed {
        rail_state_e state;
        logic [10:0] ref_mv;
        logic [16:0] oc_cnt;
        logic        oc_latch;
        logic        boot_reached;
        logic        track_fail;
        logic        track_mode;
        logic        vid_pend;
        logic [10:0] vid_target;
        rail_out_s   out;
    } rail_s;

    typedef struct packed {
        logic [2:0]       in_s1;
        logic [2:0]       in_s2;
        rail_cmp_s [1:0]  cmp_s1;
        rail_cmp_s [1:0]  cmp_s2;
        logic [1:0]       shed_s1;
        logic [1:0]       shed_s2;
        logic [4:0]       icc_s1;
        logic [4:0]       icc_s2;
        logic [2:0]       trim_s1;
        logic [2:0]       trim_s2;
        logic [5:0]       en_cnt;
        logic             en_filt;
        logic             en_rise;
        logic [4:0]       step_cnt;
        cal_state_e       cal_state;
        logic [16:0]      cal_cnt;
        logic [4:0]       icc_code;
        logic [7:0]       max_temperature_limit;
        logic             lockout;
        logic             rd_ack;
        logic             rd_unmapped;
        logic [7:0]       rd_data;
        logic [1:0]       rok_oe;
        rail_s [1:0]      rail;
    } sup_s;

endpackage

// ===== hdl/vr_supervisor_regs.svh
// offsets, reset values and timing counts of the rail supervisor
// assumes a 125 MHz system clock; all levels are in millivolts
`ifndef VR_SUPERVISOR_REGS_SVH
`define VR_SUPERVISOR_REGS_SVH

`define CLK_MHZ          125
`define MAX_SUPPORTED_CURRENT_ADDR     8'h21
`define MAX_TEMPERATURE_LIMIT_ADDR        8'h22
`define MAX_TEMPERATURE_LIMIT_RST         8'h6e
`define MAX_TEMPERATURE_LIMIT_BASE_C      8'h5a
`define BOOT_MV          11'h5dc
`define CAL_MV           11'h5f0
`define PIN_FLOOR_MV     11'h0fa
`define SLEW_MV_PER_US   5
`define STEP_CYC         (`CLK_MHZ / `SLEW_MV_PER_US)
`define EN_FILT_NS       250
`define EN_FILT_CYC      ((`EN_FILT_NS * `CLK_MHZ + 999) / 1000)
`define OC_DLY_US        256
`define OC_DLY_CYC       (`OC_DLY_US * `CLK_MHZ)
`define CAL_US           800
`define CAL_CYC          (`CAL_US * `CLK_MHZ)
`define ICC0_BASE_A      8'h3c
`define ICC0_STEP_A      8'h0a
`define ICC0_TOP_A       8'he1
`define ICC0_TOP_CODE    5'h1e
`define ICC1_LO_A        8'h19
`define ICC1_HI_A        8'h23

`endif

// ===== verification/vr_front_end_model.sv
// analog front end of one rail: comparator decisions from the reference
// assumes the bench commands faults through fault_i {oc, uv, track}
`timescale 1ns/1ps
`default_nettype none
module vr_front_end_model
    import vr_supervisor_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic [10:0] ref_i,
    input  wire logic [2:0]  fault_i,
    output rail_cmp_s        cmp_o
);
    logic [10:0] last  = 11'h000;
    logic [5:0]  still = 6'h00;
    // output follows the reference; settled once it holds past one ramp step
    always @(posedge clk_sys_i) begin
        last  <= ref_i;
        still <= (ref_i != last) ? 6'h00 : ((still == 6'h3f) ? still : still + 6'h01);
    end
    assign cmp_o = '{below_track: fault_i[0], below_uv: fault_i[1],
                     settled: (still > 6'h1e), overcurrent: fault_i[2]};
endmodule
`default_nettype wire

// ===== verification/vr_startup_fault_supervisor_tb_top.sv
// self-checking bench of the two-rail supervisor
// assumes a front-end model per rail and the bound port monitor
`timescale 1ns/1ps
`default_nettype none
module vr_startup_fault_supervisor_tb_top import vr_supervisor_pkg::*;;
    localparam int OCD = 20;
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            en = 1'b0;
    logic            v_low = 1'b0;
    logic            b_low = 1'b0;
    logic            rd = 1'b0;
    logic            rsel = 1'b0;
    logic            ack, unm, lock;
    logic [7:0]      addr = 8'h00;
    logic [7:0]      rdat;
    logic [4:0]      code = 5'h00;
    logic [2:0]      trim = 3'h0;
    logic [1:0]      shed = 2'h0;
    logic [1:0]      ok, ok_oe;
    logic [1:0][2:0] flt = '0;
    vid_cmd_s [1:0]  vid = '0;
    rail_cmp_s [1:0] cmp;
    rail_out_s [1:0] ro;
    int              mismatches = 0;
    int              comparisons = 0;
    int              cyc = 0;
    logic [7:0]      bad_q[$] = '{8'h00, 8'h20, 8'h23, 8'hff};
    vr_startup_fault_supervisor #(.OC_DLY_CYC(OCD), .CAL_CYC(50)) i_vr_startup_fault_supervisor (
        .clk_sys_i(clk), .sys_rst_i(rst), .enable_i(en), .input_supply_low_i(v_low),
        .bias_supply_low_i(b_low), .rail_cmp_i(cmp), .vid_cmd_i(vid), .phase_shed_i(shed),
        .current_limit_program_pin_i(code), .max_temperature_limit_trim_i(trim), .reg_rd_i(rd), .reg_rail_i(rsel),
        .reg_addr_i(addr), .reg_ack_o(ack), .reg_rdata_o(rdat), .reg_unmapped_o(unm),
        .supply_lockout_o(lock), .rail_o(ro), .regulator_ok_out_o(ok), .regulator_ok_out_oe_o(ok_oe));
    for (genvar g = 0; g < 2; g++) begin : g_fe
        vr_front_end_model i_vr_front_end_model (.clk_sys_i(clk), .ref_i(ro[g].int_ref), .fault_i(flt[g]),
            .cmp_o(cmp[g]));
    end
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            mismatches = mismatches + 1;
            conclude();
        end
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one read per cycle; caller lowers the strobe after the last
    task automatic rdreg(logic r, logic [7:0] a, logic [7:0] e, logic u);
        rsel = r;
        addr = a;
        rd = 1'b1;
        tick(1);
        chk("read", {6'h0, 1'b1, u, e}, {6'h0, ack, unm, rdat});
    endtask
    function automatic int icc_exp(int r, int c);
        return (r == 1) ? ((c % 2 == 1) ? 35 : 25) : ((c >= 30) ? 225 : 60 + 10 * (c / 2));
    endfunction
    initial begin
        logic [7:0] a;
        void'($urandom(32'h8d07));
        for (int c = 0; c < 32; c++) begin
            code = 5'(c);
            trim = 3'(c);
            shed = 2'(c);
            rst = 1'b1;
            tick(6);
            rst = 1'b0;
            rdreg(1'b0, 8'h22, 8'h6e, 1'b0);
            rd = 1'b0;
            tick(20);
            chk("cal_pin", 16'd1520, 16'(ro[0].pin_ref));
            tick(60);
            chk("idle_pin", 16'd250, 16'(ro[1].pin_ref));
            chk("oc_offset", 16'((4 - c % 4) * 30), 16'(ro[0].oc_offset));
            a = 8'($urandom_range(255));
            bad_q.push_back((a == 8'h21 || a == 8'h22) ? 8'h00 : a);
            rdreg(1'b0, 8'h21, 8'(icc_exp(0, c)), 1'b0);
            rdreg(1'b1, 8'h21, 8'(icc_exp(1, c)), 1'b0);
            rdreg(c[0], 8'h22, 8'(90 + 4 * (c % 8)), 1'b0);
            rdreg(1'b0, bad_q[c], 8'h00, 1'b1);
            rd = 1'b0;
        end
        flt[1] = 3'b001;
        en = 1'b1;
        tick(37000);
        chk("ready_early", 16'h0, 16'({ro[1].ready, ro[0].ready}));
        flt[1] = 3'b000;
        for (int i = 0; i < 2000 && ro[0].ready !== 1'b1; i++) begin
            tick(1);
        end
        chk("boot_ref", 16'd1500, 16'(ro[0].int_ref));
        tick(100);
        chk("ready", 16'h13, 16'({ok, ok_oe, ro[1].ready, ro[0].ready, ro[0].soft_start_done}));
        chk("boot_ref1", 16'd1500, 16'(ro[1].int_ref));
        flt[0] = 3'b001;
        tick(8);
        chk("track_loss", 16'h0, 16'(ro[0].ready));
        flt[0] = 3'b000;
        tick(8);
        chk("track_back", 16'h1, 16'(ro[0].ready));
        vid[0] = '{cmd: 1'b1, target: 11'd1510};
        tick(1);
        vid[0].cmd = 1'b0;
        tick(400);
        chk("vid_ref", 16'd1510, 16'(ro[0].int_ref));
        flt[0] = 3'b001;
        tick(8);
        chk("track_off", 16'h1, 16'(ro[0].ready));
        flt[0] = 3'b010;
        tick(8);
        chk("uv_low", 16'h0, 16'(ro[0].ready));
        flt[0] = 3'b100;
        tick(OCD - 8);
        flt[0] = 3'b000;
        tick(10);
        chk("oc_short", 16'h0, 16'(ro[0].oc_fault));
        flt[0] = 3'b100;
        tick(OCD + 8);
        chk("oc_act", 16'h0e, 16'({ro[1].oc_fault, ro[0].oc_fault, ro[0].ea_force_low,
            ro[0].drive_inhibit, ro[0].ready}));
        flt[0] = 3'b000;
        // no re-enable after the shutdown, cool-down left to the host
        for (int i = 0; i < 40000 && ro[0].int_ref !== 11'h0; i++) begin
            tick(1);
        end
        chk("down_ref", 16'd0, 16'(ro[0].int_ref));
        chk("down_pin", 16'd250, 16'(ro[0].pin_ref));
        chk("latched", 16'h1, 16'(ro[0].oc_fault));
        b_low = 1'b1;
        tick(10);
        chk("bias_clear", 16'h2, 16'({lock, ro[0].oc_fault}));
        b_low = 1'b0;
        v_low = 1'b1;
        tick(10);
        chk("in_lock", 16'h1, 16'(lock));
        conclude();
    end
endmodule
bind vr_startup_fault_supervisor vr_supervisor_monitor #(.OC_DLY_CYC(OC_DLY_CYC)) i_vr_supervisor_monitor (.*);
`default_nettype wire

// ===== verification/vr_supervisor_monitor.sv
// port checks of the supervisor
// assumes it is bound onto the supervisor top module
`timescale 1ns/1ps
`default_nettype none
module vr_supervisor_monitor
    import vr_supervisor_pkg::*;
#(
    parameter int OC_DLY_CYC = 20
) (
    input wire logic            clk_sys_i,
    input wire logic            sys_rst_i,
    input wire logic            input_supply_low_i,
    input wire logic            bias_supply_low_i,
    input wire rail_cmp_s [1:0] rail_cmp_i,
    input wire logic [2:0]      max_temperature_limit_trim_i,
    input wire logic            reg_rd_i,
    input wire logic [7:0]      reg_addr_i,
    input wire logic            reg_ack_o,
    input wire logic [7:0]      reg_rdata_o,
    input wire logic            reg_unmapped_o,
    input wire logic            supply_lockout_o,
    input wire rail_out_s [1:0] rail_o,
    input wire logic [1:0]      regulator_ok_out_oe_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    rail_out_s   r0;
    logic [16:0] oc_run;
    assign r0 = rail_o[0];
    // consecutive raw over-current cycles
    always_ff @(posedge clk_sys_i) begin
        oc_run <= (sys_rst_i || !rail_cmp_i[0].overcurrent) ? 17'h0 : oc_run + 17'h1;
    end
    property p_rd_ack;
        reg_rd_i |=> reg_ack_o && (reg_unmapped_o == !($past(reg_addr_i) inside {8'h21, 8'h22}))
            && (!reg_unmapped_o || reg_rdata_o == 8'h00);
    endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read answer wrong");
    property p_max_temperature_limit;
        reg_rd_i && reg_addr_i == 8'h22 |=> reg_rdata_o == 8'h6e || reg_rdata_o == 8'h5a + {3'h0, max_temperature_limit_trim_i, 2'h0};
    endproperty
    a_max_temperature_limit: assert property (p_max_temperature_limit) else $error("temperature limit wrong");
    property p_lockout;
        input_supply_low_i || bias_supply_low_i |-> ##[1:4] supply_lockout_o;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lockout missing");
    property p_ok_pin;
        regulator_ok_out_oe_o == ~{rail_o[1].ready, r0.ready};
    endproperty
    a_ok_pin: assert property (p_ok_pin) else $error("ready pin wrong");
    property p_ramp_gate;
        r0.int_ref < 11'h5dc && !r0.soft_start_done |-> !r0.ready;
    endproperty
    a_ramp_gate: assert property (p_ramp_gate) else $error("ready before boot");
    property p_oc_delay;
        $rose(r0.oc_fault) |-> oc_run >= OC_DLY_CYC;
    endproperty
    a_oc_delay: assert property (p_oc_delay) else $error("fault too early");
    property p_oc_effects;
        r0.oc_fault |-> r0.ea_force_low && r0.drive_inhibit ##1 !r0.ready;
    endproperty
    a_oc_effects: assert property (p_oc_effects) else $error("fault effects missing");
    property p_pin_floor;
        r0.pin_ref != 11'h0 && r0.pin_ref != 11'h5f0 |-> r0.pin_ref == ((r0.int_ref > 11'h0fa) ? r0.int_ref : 11'h0fa);
    endproperty
    a_pin_floor: assert property (p_pin_floor) else $error("pin reference wrong");
    property p_ramp_step;
        r0.pin_ref != 11'h5f0 && $changed(r0.int_ref) |-> (r0.int_ref - $past(r0.int_ref) == 11'h1
            || $past(r0.int_ref) - r0.int_ref == 11'h1) ##1 $stable(r0.int_ref)[*8];
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp slew wrong");
    c_ready: cover property ($rose(r0.ready));
    c_done: cover property ($rose(r0.soft_start_done));
    c_oc: cover property ($rose(r0.oc_fault));
    c_unmapped: cover property (reg_unmapped_o);
endmodule
`default_nettype wire
